// ==== logic/esp_pkg.sv ====
package esp_pkg;
  // Frame layout, first bit on the wire is bit 0
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam int ADDR_LSB_POS = 0;
  localparam int ADDR_MSB_POS = 1;
  localparam int OP_POS = 2;
  localparam int DATA_LSB_POS = 8;
  localparam int DATA_W = 8;
  localparam logic OP_READ = 1'h1;
  localparam logic OP_WRITE = 1'h0;
  // Reset values of the stored configuration words
  localparam logic [7:0] REG0_RESET = 8'h80;
  localparam logic [7:0] REG1_RESET = 8'h73;
  // Program strobe must stand this long before it commits
  localparam int PROG_MIN_MS = 5;
  localparam int CLK_MHZ = 125;
  localparam int PROG_MIN_CYC = PROG_MIN_MS * 1000 * CLK_MHZ;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {
    ESP_IDLE = 2'b00,
    ESP_SHIFT = 2'b01,
    ESP_HELD = 2'b10
  } esp_state_t;
endpackage

// ==== logic/esp_program_port.sv ====
`timescale 1ns/1ns
module esp_program_port
  import esp_pkg::*;
#(
  parameter int PROG_CYC = PROG_MIN_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Programming pins
  input wire logic testMode,
  input wire logic serialClk,
  input wire logic transferEnable,
  input wire logic serialIn,
  input wire logic progStrobe,
  output logic serialOut,
  output logic serialOutEn_n,
  // Stored configuration and port status
  output logic [7:0] cfgWord0,
  output logic [7:0] cfgWord1,
  output logic portActive
);

  // ==========================================
  // Pin synchronisers
  logic [2:0] tmSync_ff, sckSync_ff, enSync_ff, siSync_ff, ppSync_ff;
  logic [2:0] nxt_tmSync, nxt_sckSync, nxt_enSync, nxt_siSync, nxt_ppSync;
  logic tm_ff, sck_ff, en_ff, si_ff, pp_ff;
  logic nxt_tm, nxt_sck, nxt_en, nxt_si, nxt_pp;

  // A change only counts once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  always_comb begin
    nxt_tmSync = {tmSync_ff[1:0], testMode};
    nxt_sckSync = {sckSync_ff[1:0], serialClk};
    nxt_enSync = {enSync_ff[1:0], transferEnable};
    nxt_siSync = {siSync_ff[1:0], serialIn};
    nxt_ppSync = {ppSync_ff[1:0], progStrobe};
    nxt_tm = filt(tmSync_ff, tm_ff);
    nxt_sck = filt(sckSync_ff, sck_ff);
    nxt_en = filt(enSync_ff, en_ff);
    nxt_si = filt(siSync_ff, si_ff);
    nxt_pp = filt(ppSync_ff, pp_ff);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tmSync_ff <= SYNC_RESET;
      sckSync_ff <= SYNC_RESET;
      enSync_ff <= SYNC_RESET;
      siSync_ff <= SYNC_RESET;
      ppSync_ff <= SYNC_RESET;
      tm_ff <= 1'h0;
      sck_ff <= 1'h0;
      en_ff <= 1'h0;
      si_ff <= 1'h0;
      pp_ff <= 1'h0;
    end else begin
      tmSync_ff <= nxt_tmSync;
      sckSync_ff <= nxt_sckSync;
      enSync_ff <= nxt_enSync;
      siSync_ff <= nxt_siSync;
      ppSync_ff <= nxt_ppSync;
      tm_ff <= nxt_tm;
      sck_ff <= nxt_sck;
      en_ff <= nxt_en;
      si_ff <= nxt_si;
      pp_ff <= nxt_pp;
    end
  end

  logic sckRise, enRise;
  assign sckRise = nxt_sck & ~sck_ff;
  assign enRise = nxt_en & ~en_ff;

  // ==========================================
  // Frame engine
  esp_state_t state_ff, nxt_state;
  logic [15:0] shift_ff, nxt_shift;
  logic [4:0] count_ff, nxt_count;
  logic [7:0] inReg_ff, nxt_inReg;
  logic inAddr_ff, nxt_inAddr;
  logic armed_ff, nxt_armed;
  logic [7:0] readBuf_ff, nxt_readBuf;
  logic so_ff, nxt_so;
  logic soEn_n_ff, nxt_soEn_n;
  logic [7:0] mem_ff [2];
  logic [7:0] nxt_mem [2];
  logic [31:0] ppCnt_ff, nxt_ppCnt;
  logic [1:0] rdAddr;
  logic [15:0] fullFrame;

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_count = count_ff;
    nxt_inReg = inReg_ff;
    nxt_inAddr = inAddr_ff;
    nxt_armed = armed_ff;
    nxt_readBuf = readBuf_ff;
    nxt_so = so_ff;
    nxt_soEn_n = 1'h1;
    nxt_mem = mem_ff;
    nxt_ppCnt = '0;
    rdAddr = '0;
    // Shift LSB first: bit arriving first ends up at position 0
    fullFrame = {si_ff, shift_ff[15:1]};
    if (!tm_ff) begin
      // Normal pins: port idle, output released
      nxt_state = ESP_IDLE;
      nxt_count = '0;
      nxt_armed = 1'h0;
    end else begin
      nxt_soEn_n = 1'h0;
      case (state_ff)
        ESP_IDLE: begin
          if (enRise) begin
            nxt_state = ESP_SHIFT;
            nxt_count = '0;
          end
        end
        ESP_SHIFT: begin
          if (!nxt_en) begin
            // Short frames are dropped; the pending commit and the stored words stay as they were
            nxt_state = ESP_IDLE;
          end else if (sckRise) begin
            nxt_shift = {nxt_si, shift_ff[15:1]};
            nxt_so = readBuf_ff[0];
            nxt_readBuf = {1'h0, readBuf_ff[7:1]};
            // After the op bit, load the addressed word for read-back
            if (count_ff == 5'h2 && nxt_si == OP_READ) begin
              rdAddr = {shift_ff[15], shift_ff[14]};
              nxt_readBuf = mem_ff[rdAddr[0]];
            end
            nxt_count = count_ff + 5'h1;
            if (count_ff == FRAME_LAST) begin
              nxt_state = ESP_HELD;
            end
          end
        end
        ESP_HELD: begin
          if (!nxt_en) begin
            fullFrame = shift_ff;
            nxt_state = ESP_IDLE;
            // Only write frames arm a commit; read data is ignored
            if (fullFrame[OP_POS] == OP_WRITE) begin
              nxt_inReg = fullFrame[DATA_LSB_POS +: DATA_W];
              nxt_inAddr = fullFrame[ADDR_LSB_POS];
              nxt_armed = 1'h1;
            end else begin
              nxt_armed = 1'h0;
            end
          end
        end
        default: nxt_state = ESP_IDLE;
      endcase
      // Commit only with transfer_enable low; one commit per arm
      if (pp_ff && !en_ff && state_ff == ESP_IDLE) begin
        nxt_ppCnt = (ppCnt_ff == 32'(PROG_CYC)) ? ppCnt_ff : ppCnt_ff + 32'h1;
        if (armed_ff && ppCnt_ff == 32'(PROG_CYC) - 32'h1) begin
          nxt_mem[inAddr_ff] = inReg_ff;
          nxt_armed = 1'h0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ESP_IDLE;
      shift_ff <= 16'h0000;
      count_ff <= 5'h00;
      inReg_ff <= 8'h00;
      inAddr_ff <= 1'h0;
      armed_ff <= 1'h0;
      readBuf_ff <= 8'h00;
      so_ff <= 1'h0;
      soEn_n_ff <= 1'h1;
      mem_ff[0] <= REG0_RESET;
      mem_ff[1] <= REG1_RESET;
      ppCnt_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      count_ff <= nxt_count;
      inReg_ff <= nxt_inReg;
      inAddr_ff <= nxt_inAddr;
      armed_ff <= nxt_armed;
      readBuf_ff <= nxt_readBuf;
      so_ff <= nxt_so;
      soEn_n_ff <= nxt_soEn_n;
      mem_ff <= nxt_mem;
      ppCnt_ff <= nxt_ppCnt;
    end
  end

  assign serialOut = so_ff;
  assign serialOutEn_n = soEn_n_ff;
  assign cfgWord0 = mem_ff[0];
  assign cfgWord1 = mem_ff[1];
  assign portActive = tm_ff;

endmodule

// ==== tb/esp_chk_assertions.sv ====
`timescale 1ns/1ns
// ======
// Port checker
module esp_chk
  import esp_pkg::*;
#(parameter int PROG_CYC = PROG_MIN_CYC) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and state
  input wire logic testMode,
  input wire logic progStrobe,
  input wire logic serialOutEn_n,
  input wire logic [7:0] cfgWord0,
  input wire logic [7:0] cfgWord1,
  input wire logic portActive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_reset_words: assert property ($fell(rst) |-> {cfgWord1, cfgWord0} == {REG1_RESET, REG0_RESET})
    else $error("reset words");
  chk_mode_on: assert property (testMode [*8] |-> portActive)
    else $error("port not active");
  chk_mode_off: assert property (!testMode [*8] |-> !portActive)
    else $error("port still active");
  chk_drive_on: assert property (portActive [*3] |-> !serialOutEn_n)
    else $error("output not driven");
  chk_drive_off: assert property (!portActive [*3] |-> serialOutEn_n)
    else $error("output driven idle");
  chk_words_hold: assert property (!progStrobe [*8] |=> $stable({cfgWord1, cfgWord0}))
    else $error("unstrobed change");
  // Commit needs the strobe already up a full programming time earlier
  chk_strobe_time: assert property ($changed({cfgWord1, cfgWord0}) |-> $past(progStrobe, PROG_CYC))
    else $error("strobe too short");
  chk_one_word: assert property (!($changed(cfgWord0) && $changed(cfgWord1)))
    else $error("two words written");
  cover property ($changed(cfgWord0));
  cover property ($changed(cfgWord1));
  cover property ($fell(portActive));
endmodule
bind esp_program_port esp_chk #(.PROG_CYC(PROG_CYC)) i_esp_chk (.*);

// ==== tb/esp_pgm.sv ====
`timescale 1ns/1ns
// ======
// Programmer on the far side of the port
module esp_pgm (
  // Clock
  input wire logic sys_clk,
  // Port pins
  output logic testMode,
  output logic serialClk,
  output logic transferEnable,
  output logic serialIn,
  output logic progStrobe,
  input wire logic serialOut
);
  initial {testMode, serialClk, transferEnable, serialIn, progStrobe} = 5'h00;
  task automatic mode(input logic m);
    @(posedge sys_clk) testMode <= m;
    repeat (8) @(posedge sys_clk);
  endtask
  // Serial clock has no phase tie to sys_clk and rests low between frames
  task automatic frame(input logic [15:0] f, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #41 transferEnable = 1'h1;
    for (int k = 0; k < n; k++) begin
      serialIn = f[k];
      #62 serialClk = 1'h1;
      #63 if (k > 2 && k < 11) rd[k-3] = serialOut;
      serialClk = 1'h0;
    end
    #41 transferEnable = 1'h0;
  endtask
  // Wait lets the closed frame settle before the strobe rises
  task automatic strobe(input int cyc);
    repeat (4) @(posedge sys_clk);
    progStrobe <= 1'h1;
    repeat (cyc) @(posedge sys_clk);
    progStrobe <= 1'h0;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

// ==== tb/eeprom_serial_program_port_test.sv ====
`timescale 1ns/1ns
// ======
// Bench
module eeprom_serial_program_port_test;
  import esp_pkg::*;
  localparam int PCYC = 20;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic testMode, serialClk, transferEnable, serialIn, progStrobe, serialOut, serialOutEn_n, portActive;
  logic [7:0] cfgWord0, cfgWord1, rd;
  logic [15:0] expW;
  wire logic [15:0] words = {cfgWord1, cfgWord0};
  int n_mismatch = 0;
  int tests_run = 0;
  esp_program_port #(.PROG_CYC(PCYC)) i_esp_program_port (.*);
  esp_pgm i_esp_pgm (.*);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic check(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic run(input logic a, op, input logic [7:0] d, input int n, s);
    i_esp_pgm.frame({d, 5'h00, op, 1'h0, a}, n, rd);
    if (s > 0) i_esp_pgm.strobe(s);
  endtask
  task automatic stop_test();
    $display("%0d checks, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    logic [7:0] d;
    logic a;
    expW = {REG1_RESET, REG0_RESET};
    void'($urandom(10093));
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    check("reset", words, expW);
    i_esp_pgm.mode(1'h1);
    for (int i = 0; i < 6; i++) begin
      a = i[0];
      d = (i < 2) ? {i[0], 6'h00, ~i[0]} : 8'($urandom);
      run(a, OP_READ, 8'h00, 16, 0);
      check("read", {8'h00, rd}, {8'h00, expW[a*8 +: 8]});
      run(a, OP_WRITE, d, 16, (i == 2) ? PCYC - 4 : 0);
      check("early", words, expW);
      i_esp_pgm.strobe(PCYC + 12);
      expW[a*8 +: 8] = d;
      check("write", words, expW);
    end
    run(1'h0, OP_READ, 8'h00, 16, 0);
    run(1'h0, OP_WRITE, 8'h5a, 10, PCYC + 12);
    check("partial", words, expW);
    i_esp_pgm.mode(1'h0);
    run(1'h1, OP_WRITE, 8'ha5, 16, PCYC + 12);
    check("off", words, expW);
    stop_test();
  end
endmodule
